// ---- core/sel_loader.sv ----
// serial record loader: option, record parsing, memory programming, verify
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "sel_map.svh"
// Function
// - every character taken in the option, seek, type or byte state is echoed back at once
// - verify mismatch sends the stored byte back after the echo
// - programming read-back mismatch stops all responses; host aborts
// - setup register target skips the read-back check
// - new setup value takes effect only after the next reset
// - mode select bit is set before any programming
// - on-chip byte is erased to all ones, then written
// - address and data latched while programming voltage is on
// - on-chip programming time is counted by the loader
// - external write completion polled on the top data bit
// - option letter I, X or V applies to the whole file
// - 8K external part aliases C000-DFFF onto E000-FFFF
// - termination record with nonzero address jumps there
// - type 1 carries data; type 0 is a header only
// - record is length, address high, address low, data, checksum
// - characters after the type digit are hex digit pairs, high nibble first
// - checksum byte is read but never checked
// - record link runs eight data bits at 9600 baud
// - external polling starts half a millisecond after each write
module sel_loader #(
  parameter int PROG_CYC = `SEL_PROG_CYC,
  parameter int POLL_CYC = `SEL_POLL_CYC,
  parameter int BIT_CYC = `SEL_BIT_CYC,
  parameter bit EXT_16K = 1'b0
) (
  // system
  input wire logic clk,
  input wire logic rstn,
  input wire logic porRstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link
  input wire logic rxd,
  output logic txd,
  // memory bus, read data valid while memRd is high
  output logic [15:0] memAddr,
  output logic [7:0] memWdata,
  output logic memWr,
  output logic memRd,
  input wire logic [7:0] memRdata,
  // on-chip eeprom and mode controls
  output logic eeVolt,
  output logic eeLatch,
  output logic eeErase,
  output logic modeSelect,
  output logic [7:0] configActive,
  // execution transfer
  output logic [15:0] jumpAddr,
  output logic jumpStb
);
  localparam logic [19:0] PROGN = 20'(PROG_CYC - 1);
  localparam logic [19:0] POLLN = 20'(POLL_CYC - 1);
  localparam sel_pkg::sel_core_t RST_C = '{
    st: sel_pkg::S_IDLE, opt: sel_pkg::OPT_INT, rec: sel_pkg::REC_HDR,
    eeCtl: `SEL_EECTL_RST, modeReg: `SEL_MODE_RST,
    cfgPend: `SEL_CFG_RST, cfgActive: `SEL_CFG_RST, default: '0};

  sel_pkg::sel_core_t s;
  sel_pkg::sel_core_t n;
  logic take;
  sel_uart_if uif();

  sel_uart #(.BIT_CYC(BIT_CYC)) uart (
    .clk(clk),
    .rstn(rstn),
    .rxd(rxd),
    .txd(txd),
    .u(uif.uart)
  );

  function automatic logic [3:0] hexVal(input logic [7:0] c);
    if (c >= 8'h61)
      hexVal = 4'(c - 8'h57);
    else if (c >= 8'h41)
      hexVal = 4'(c - 8'h37);
    else
      hexVal = c[3:0];
  endfunction

  function automatic logic [15:0] mapAddr(input logic [15:0] a);
    if (!EXT_16K && a[15:13] == 3'h6)
      mapAddr = {3'h7, a[12:0]};
    else
      mapAddr = a;
  endfunction

  function automatic sel_pkg::sel_reg_t regSel(input logic [15:0] a);
    if (a[1:0] != 2'h0)
      regSel = sel_pkg::RS_NONE;
    else if (a[15:2] == `SEL_IDX_EECTL)
      regSel = sel_pkg::RS_EECTL;
    else if (a[15:2] == `SEL_IDX_MODE)
      regSel = sel_pkg::RS_MODE;
    else if (a[15:2] == `SEL_IDX_CFG)
      regSel = sel_pkg::RS_CFG;
    else if (a[15:2] == `SEL_IDX_CTRL)
      regSel = sel_pkg::RS_CTRL;
    else if (a[15:2] == `SEL_IDX_STAT)
      regSel = sel_pkg::RS_STAT;
    else
      regSel = sel_pkg::RS_NONE;
  endfunction

  always_comb
  begin
    sel_pkg::sel_reg_t rs;
    logic [7:0] b;
    rs = regSel(paddr);
    n = s;
    b = {s.hiNib, hexVal(s.rxHold)};
    n.txStb = 1'b0;
    n.memWr = 1'b0;
    n.memRd = 1'b0;
    n.jumpStb = 1'b0;
    // read data is caught in setup so it stands through the access cycle
    n.pready = psel & ~penable;
    n.pslverr = 1'b0;
    if (psel && !penable)
    begin
      n.pslverr = (rs == sel_pkg::RS_NONE);
      if (rs == sel_pkg::RS_EECTL)
        n.prdata = {24'h0, s.eeCtl};
      else if (rs == sel_pkg::RS_MODE)
        n.prdata = {24'h0, s.modeReg};
      else if (rs == sel_pkg::RS_CFG)
        n.prdata = {24'h0, s.cfgActive};
      else if (rs == sel_pkg::RS_CTRL)
        n.prdata = {31'h0, s.enable};
      else if (rs == sel_pkg::RS_STAT)
        n.prdata = {s.jumpAddr, 6'h0, s.opt, s.hung, 2'h0, s.st};
      else
        n.prdata = 32'h0;
    end
    if (psel && penable && s.pready && pwrite)
    begin
      if (rs == sel_pkg::RS_EECTL)
        n.eeCtl = pwdata[7:0];
      else if (rs == sel_pkg::RS_MODE)
        n.modeReg = pwdata[7:0];
      else if (rs == sel_pkg::RS_CFG)
        n.cfgPend = pwdata[7:0];
      else if (rs == sel_pkg::RS_CTRL)
        n.enable = pwdata[`SEL_CTRL_EN];
    end
    // one character is held; the host paces itself on the echo
    take = s.rxFull && !uif.txBusy && !s.txStb &&
      (s.st == sel_pkg::S_OPT || s.st == sel_pkg::S_SEEK ||
       s.st == sel_pkg::S_TYPE || s.st == sel_pkg::S_BYTE);
    if (take)
    begin
      n.rxFull = 1'b0;
      n.txStb = 1'b1;
      n.txByte = s.rxHold;
    end
    if (uif.rxStb)
    begin
      n.rxFull = 1'b1;
      n.rxHold = uif.rxByte;
    end
    case (s.st)
      sel_pkg::S_IDLE:
      begin
        n.rxFull = 1'b0;
        if (s.enable)
        begin
          n.modeReg[`SEL_MDA_BIT] = 1'b1;
          n.hung = 1'b0;
          n.st = sel_pkg::S_OPT;
        end
      end
      sel_pkg::S_OPT:
      begin
        if (take)
        begin
          if (s.rxHold == `SEL_CH_I)
          begin
            n.opt = sel_pkg::OPT_INT;
            n.st = sel_pkg::S_SEEK;
          end
          else if (s.rxHold == `SEL_CH_X)
          begin
            n.opt = sel_pkg::OPT_EXT;
            n.st = sel_pkg::S_SEEK;
          end
          else if (s.rxHold == `SEL_CH_V)
          begin
            n.opt = sel_pkg::OPT_VFY;
            n.st = sel_pkg::S_SEEK;
          end
        end
      end
      sel_pkg::S_SEEK:
      begin
        if (take && s.rxHold == `SEL_CH_S)
          n.st = sel_pkg::S_TYPE;
      end
      sel_pkg::S_TYPE:
      begin
        if (take)
        begin
          if (s.rxHold == `SEL_CH_1)
            n.rec = sel_pkg::REC_DATA;
          else if (s.rxHold == `SEL_CH_9)
            n.rec = sel_pkg::REC_TERM;
          else
            n.rec = sel_pkg::REC_HDR;
          n.field = 2'h0;
          n.nib = 1'b0;
          n.st = sel_pkg::S_BYTE;
        end
      end
      sel_pkg::S_BYTE:
      begin
        if (take && !s.nib)
        begin
          n.nib = 1'b1;
          n.hiNib = hexVal(s.rxHold);
        end
        else if (take)
        begin
          n.nib = 1'b0;
          if (s.field == 2'h0)
          begin
            n.cnt = b;
            n.field = 2'h1;
          end
          else
          begin
            n.cnt = s.cnt - 8'h01;
            if (s.field == 2'h1)
            begin
              n.addr[15:8] = b;
              n.field = 2'h2;
            end
            else if (s.field == 2'h2)
            begin
              n.addr[7:0] = b;
              n.field = 2'h3;
            end
            else if (s.cnt == 8'h01)
            begin
              // checksum byte consumed, value unused
              if (s.rec == sel_pkg::REC_TERM && s.addr != 16'h0)
              begin
                n.jumpAddr = s.addr;
                n.jumpStb = 1'b1;
                n.st = sel_pkg::S_STOP;
              end
              else
                n.st = sel_pkg::S_SEEK;
            end
            else if (s.rec == sel_pkg::REC_DATA)
            begin
              n.data = b;
              n.memAddr = mapAddr(s.addr);
              n.memWdata = b;
              n.modeReg[`SEL_MDA_BIT] = 1'b1;
              if (s.opt == sel_pkg::OPT_VFY)
                n.st = sel_pkg::S_RD;
              else if (s.addr == `SEL_CFG_ADDR)
              begin
                // no read-back: the stored value stays hidden until reset
                n.cfgPend = b;
                n.addr = s.addr + 16'h1;
              end
              else if (s.opt == sel_pkg::OPT_INT)
              begin
                n.phase = 1'b0;
                n.st = sel_pkg::S_IE_LAT;
              end
              else
              begin
                n.memWr = 1'b1;
                n.tmr = POLLN;
                n.st = sel_pkg::S_EXT_DLY;
              end
            end
          end
        end
      end
      sel_pkg::S_IE_LAT:
      begin
        n.eeCtl = 8'h00;
        n.eeCtl[`SEL_EE_LAT] = 1'b1;
        n.eeCtl[`SEL_EE_ERASE] = ~s.phase;
        n.memWdata = s.phase ? s.data : `SEL_ERASED;
        n.memWr = 1'b1;
        n.st = sel_pkg::S_IE_ON;
      end
      sel_pkg::S_IE_ON:
      begin
        n.eeCtl[`SEL_EE_VPP] = 1'b1;
        n.tmr = PROGN;
        n.st = sel_pkg::S_IE_HV;
      end
      sel_pkg::S_IE_HV:
      begin
        if (s.tmr == 20'h0)
        begin
          n.eeCtl[`SEL_EE_VPP] = 1'b0;
          n.st = sel_pkg::S_IE_END;
        end
        else
          n.tmr = s.tmr - 20'h1;
      end
      sel_pkg::S_IE_END:
      begin
        n.eeCtl = 8'h00;
        n.phase = 1'b1;
        n.st = s.phase ? sel_pkg::S_RD : sel_pkg::S_IE_LAT;
      end
      sel_pkg::S_EXT_DLY:
      begin
        if (s.tmr == 20'h0)
          n.st = sel_pkg::S_RD;
        else
          n.tmr = s.tmr - 20'h1;
      end
      sel_pkg::S_RD:
      begin
        n.memRd = 1'b1;
        n.st = sel_pkg::S_CHK;
      end
      sel_pkg::S_CHK:
      begin
        n.addr = s.addr + 16'h1;
        n.st = sel_pkg::S_BYTE;
        if (s.opt == sel_pkg::OPT_VFY && memRdata != s.data)
        begin
          n.rdByte = memRdata;
          n.addr = s.addr;
          n.st = sel_pkg::S_SEND_BAD;
        end
        else if (s.opt == sel_pkg::OPT_EXT && memRdata[7] != s.data[7])
        begin
          n.addr = s.addr;
          n.st = sel_pkg::S_RD;
        end
        else if (s.opt != sel_pkg::OPT_VFY && memRdata != s.data)
        begin
          n.addr = s.addr;
          n.hung = 1'b1;
          n.st = sel_pkg::S_HANG;
        end
      end
      sel_pkg::S_SEND_BAD:
      begin
        if (!uif.txBusy && !s.txStb)
        begin
          n.txStb = 1'b1;
          n.txByte = s.rdByte;
          n.addr = s.addr + 16'h1;
          n.st = sel_pkg::S_BYTE;
        end
      end
      default:
      begin
        n.st = s.st;
      end
    endcase
    // software abort; programming voltage is dropped at once
    if (!s.enable && s.st != sel_pkg::S_IDLE)
    begin
      n.st = sel_pkg::S_IDLE;
      n.eeCtl = 8'h00;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!porRstn)
      s <= RST_C;
    else if (!rstn)
    begin
      s <= RST_C;
      s.cfgPend <= s.cfgPend;
      s.cfgActive <= s.cfgPend;
    end
    else
      s <= n;
  end

  assign uif.txStb = s.txStb;
  assign uif.txByte = s.txByte;
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign memAddr = s.memAddr;
  assign memWdata = s.memWdata;
  assign memWr = s.memWr;
  assign memRd = s.memRd;
  assign eeVolt = s.eeCtl[`SEL_EE_VPP];
  assign eeLatch = s.eeCtl[`SEL_EE_LAT];
  assign eeErase = s.eeCtl[`SEL_EE_ERASE];
  assign modeSelect = s.modeReg[`SEL_MDA_BIT];
  assign configActive = s.cfgActive;
  assign jumpAddr = s.jumpAddr;
  assign jumpStb = s.jumpStb;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  echo_on_take_a: assert property (take |=> s.txStb && s.txByte == $past(s.rxHold))
    else $error("received character not echoed");
  bad_byte_sent_a: assert property (
    s.st == sel_pkg::S_CHK && s.opt == sel_pkg::OPT_VFY && memRdata != s.data
    |=> ##[1:400] (s.txStb && s.txByte == $past(s.rdByte)))
    else $error("verify mismatch byte not returned");
  hang_silent_a: assert property (s.st == sel_pkg::S_HANG |=> !s.txStb && s.st == sel_pkg::S_HANG)
    else $error("loader answered after a failed write");
  cfg_no_check_a: assert property (
    s.st == sel_pkg::S_CHK |-> s.opt == sel_pkg::OPT_VFY || s.memAddr != `SEL_CFG_ADDR)
    else $error("setup register read back after programming");
  cfg_at_reset_a: assert property (
    @(posedge clk) disable iff (!porRstn) rstn && $past(rstn) |-> $stable(s.cfgActive))
    else $error("setup value changed without a reset");
  mode_before_wr_a: assert property (s.memWr |-> s.modeReg[`SEL_MDA_BIT])
    else $error("memory written before mode select");
  erase_first_a: assert property (
    s.st == sel_pkg::S_IE_LAT && !s.phase
    |=> s.memWr && s.memWdata == `SEL_ERASED && s.eeCtl[`SEL_EE_ERASE] ##2 s.eeCtl[`SEL_EE_VPP])
    else $error("erase step wrong");
  latch_held_a: assert property (s.eeCtl[`SEL_EE_VPP] |-> s.eeCtl[`SEL_EE_LAT])
    else $error("voltage on without latches");
  vpp_counted_a: assert property (s.st == sel_pkg::S_IE_HV && s.tmr != 20'h0 |=> s.eeCtl[`SEL_EE_VPP])
    else $error("programming voltage cut short");
  poll_msb_a: assert property (
    s.st == sel_pkg::S_CHK && s.opt == sel_pkg::OPT_EXT && memRdata[7] != s.data[7]
    |=> s.st == sel_pkg::S_RD ##1 s.memRd)
    else $error("external poll stopped early");
  alias_8k_a: assert property ((s.memWr || s.memRd) && !EXT_16K |-> s.memAddr[15:13] != 3'h6)
    else $error("address outside aliased window");
  jump_nonzero_a: assert property (s.jumpStb |-> s.jumpAddr != 16'h0 && s.st == sel_pkg::S_STOP)
    else $error("jump to zero");
  poll_delay_a: assert property (s.st == sel_pkg::S_EXT_DLY && s.tmr != 20'h0 |=> !s.memRd)
    else $error("polling began before the delay");

  ext_poll_c: cover property (s.st == sel_pkg::S_CHK && s.opt == sel_pkg::OPT_EXT ##1 s.st == sel_pkg::S_RD);
  vfy_bad_c: cover property (s.st == sel_pkg::S_SEND_BAD ##[1:400] s.txStb);
  int_prog_c: cover property (s.st == sel_pkg::S_IE_END && s.phase);
  jump_c: cover property (s.jumpStb);
endmodule // sel_loader
`default_nettype wire

// ---- include/sel_map.svh ----
// offsets, field positions, reset values and timing counts of the loader
`ifndef SEL_MAP_SVH
`define SEL_MAP_SVH

// register indices; byte address on the bus is four times the index
`define SEL_IDX_EECTL 14'h103b
`define SEL_IDX_MODE 14'h103c
`define SEL_IDX_CFG 14'h103f
`define SEL_IDX_CTRL 14'h1040
`define SEL_IDX_STAT 14'h1041

// target address of the system setup register in the load map
`define SEL_CFG_ADDR 16'h103f

// field positions
`define SEL_MDA_BIT 5
`define SEL_EE_VPP 0
`define SEL_EE_LAT 1
`define SEL_EE_ERASE 2
`define SEL_CTRL_EN 0

// reset values and the erased byte value
`define SEL_EECTL_RST 8'h00
`define SEL_MODE_RST 8'h00
`define SEL_CFG_RST 8'hff
`define SEL_ERASED 8'hff

// characters
`define SEL_CH_S 8'h53
`define SEL_CH_I 8'h49
`define SEL_CH_X 8'h58
`define SEL_CH_V 8'h56
`define SEL_CH_1 8'h31
`define SEL_CH_9 8'h39

// timing
`define SEL_CLK_NS 25
`define SEL_PROG_NS 10000000
`define SEL_PROG_CYC ((`SEL_PROG_NS + `SEL_CLK_NS - 1) / `SEL_CLK_NS)
`define SEL_POLL_NS 500000
`define SEL_POLL_CYC ((`SEL_POLL_NS + `SEL_CLK_NS - 1) / `SEL_CLK_NS)
`define SEL_BAUD 9600
`define SEL_BIT_CYC (1000000000 / (`SEL_BAUD * `SEL_CLK_NS))

`endif

// ---- include/sel_pkg.sv ----
// types shared by the loader core and its serial port
package sel_pkg;
  typedef enum logic [4:0] {
    S_IDLE = 5'h00, S_OPT = 5'h01, S_SEEK = 5'h02, S_TYPE = 5'h03,
    S_BYTE = 5'h04, S_IE_LAT = 5'h05, S_IE_ON = 5'h06, S_IE_HV = 5'h07,
    S_IE_END = 5'h08, S_EXT_DLY = 5'h09, S_RD = 5'h0a, S_CHK = 5'h0b,
    S_SEND_BAD = 5'h0c, S_HANG = 5'h0d, S_STOP = 5'h0e
  } sel_state_t;
  typedef enum logic [1:0] {OPT_INT = 2'h0, OPT_EXT = 2'h1, OPT_VFY = 2'h2} sel_opt_t;
  typedef enum logic [1:0] {REC_HDR = 2'h0, REC_DATA = 2'h1, REC_TERM = 2'h2} sel_rec_t;
  typedef enum logic [2:0] {
    RS_NONE = 3'h0, RS_EECTL = 3'h1, RS_MODE = 3'h2, RS_CFG = 3'h3,
    RS_CTRL = 3'h4, RS_STAT = 3'h5
  } sel_reg_t;
  typedef struct packed {
    sel_state_t st; sel_opt_t opt; sel_rec_t rec;
    logic enable; logic hung; logic nib; logic phase;
    logic [3:0] hiNib; logic [1:0] field; logic [7:0] cnt;
    logic [15:0] addr; logic [7:0] data; logic [7:0] rdByte; logic [19:0] tmr;
    logic [7:0] eeCtl; logic [7:0] modeReg; logic [7:0] cfgPend; logic [7:0] cfgActive;
    logic rxFull; logic [7:0] rxHold; logic txStb; logic [7:0] txByte;
    logic [15:0] memAddr; logic [7:0] memWdata; logic memWr; logic memRd;
    logic [15:0] jumpAddr; logic jumpStb;
    logic [31:0] prdata; logic pready; logic pslverr;
  } sel_core_t;
  typedef struct packed {
    logic rxS1; logic rxS2; logic rxBusy; logic [15:0] rxCnt; logic [3:0] rxBit;
    logic [7:0] rxSh; logic rxStb; logic [7:0] rxByte;
    logic txBusy; logic [15:0] txCnt; logic [3:0] txBit; logic [9:0] txSh;
  } sel_uart_t;
endpackage

// ---- include/sel_uart_if.sv ----
// byte path between the loader core and its serial port
`timescale 1ns/10ps
`default_nettype none
interface sel_uart_if;
  logic rxStb;
  logic [7:0] rxByte;
  logic txStb;
  logic [7:0] txByte;
  logic txBusy;
  modport core (input rxStb, input rxByte, input txBusy, output txStb, output txByte);
  modport uart (output rxStb, output rxByte, output txBusy, input txStb, input txByte);
endinterface
`default_nettype wire

// ---- core/sel_uart.sv ----
// 8N1 serial port: synchronised receiver and transmitter
`timescale 1ns/10ps
`default_nettype none
`include "sel_map.svh"
module sel_uart #(
  parameter int BIT_CYC = `SEL_BIT_CYC
) (
  // system
  input wire logic clk,
  input wire logic rstn,
  // pins
  input wire logic rxd,
  output logic txd,
  // byte side
  sel_uart_if.uart u
);
  localparam logic [15:0] BITN = 16'(BIT_CYC - 1);
  localparam logic [15:0] HALF = 16'(BIT_CYC / 2);
  sel_pkg::sel_uart_t s;
  sel_pkg::sel_uart_t n;

  always_comb
  begin
    n = s;
    n.rxS1 = rxd;
    n.rxS2 = s.rxS1;
    n.rxStb = 1'b0;
    if (!s.rxBusy)
    begin
      if (!s.rxS2)
      begin
        n.rxBusy = 1'b1;
        n.rxCnt = HALF;
        n.rxBit = 4'h0;
      end
    end
    else if (s.rxCnt != 16'h0)
      n.rxCnt = s.rxCnt - 16'h1;
    else
    begin
      n.rxCnt = BITN;
      n.rxBit = s.rxBit + 4'h1;
      // a glitch shorter than half a bit is not a start
      if (s.rxBit == 4'h0 && s.rxS2)
        n.rxBusy = 1'b0;
      else if (s.rxBit == 4'h9)
      begin
        n.rxBusy = 1'b0;
        n.rxStb = 1'b1;
        n.rxByte = s.rxSh;
      end
      else if (s.rxBit != 4'h0)
        n.rxSh = {s.rxS2, s.rxSh[7:1]};
    end
    if (!s.txBusy)
    begin
      if (u.txStb)
      begin
        n.txBusy = 1'b1;
        n.txSh = {1'b1, u.txByte, 1'b0};
        n.txCnt = BITN;
        n.txBit = 4'h0;
      end
    end
    else if (s.txCnt != 16'h0)
      n.txCnt = s.txCnt - 16'h1;
    else
    begin
      n.txCnt = BITN;
      n.txSh = {1'b1, s.txSh[9:1]};
      n.txBit = s.txBit + 4'h1;
      if (s.txBit == 4'h9)
        n.txBusy = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      s <= '{rxS1: 1'b1, rxS2: 1'b1, txSh: 10'h3ff, default: '0};
    else
      s <= n;
  end

  assign txd = s.txSh[0];
  assign u.rxStb = s.rxStb;
  assign u.rxByte = s.rxByte;
  assign u.txBusy = s.txBusy;
endmodule // sel_uart
`default_nettype wire

// ---- tb/sel_mem_model.sv ----
// memory partner: ram with external eeprom write-busy behaviour
`timescale 1ns/10ps
`default_nettype none
module sel_mem_model #(
  parameter int BUSY = 14
) (
  // system
  input wire logic clk,
  // memory bus
  input wire logic [15:0] memAddr,
  input wire logic [7:0] memWdata,
  input wire logic memWr,
  input wire logic memRd,
  output logic [7:0] memRdata
);
  logic [7:0] mem [0:65535];
  int busy = 0;
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = i[7:0] ^ 8'h5a;
  end
  always @(posedge clk)
  begin
    if (busy > 0)
      busy <= busy - 1;
    // 8000-8fff is read-only, so a write there never lands
    if (memWr && memAddr[15:12] != 4'h8)
    begin
      mem[memAddr] <= memWdata;
      busy <= BUSY;
    end
  end
  // released bus shows the inverse, not the last value
  assign memRdata = !memRd ? ~mem[memAddr] : mem[memAddr] ^ {busy > 0, 7'h0};
endmodule // sel_mem_model
`default_nettype wire

// ---- tb/sel_loader_tb_top.sv ----
// loader bench: apb master, serial host with echo queue, memory partner
`timescale 1ns/10ps
`default_nettype none
module sel_loader_tb_top;
  localparam int BIT = 16;
  localparam int PROG = 20;
  logic clk = 1'b0, rstn = 1'b0, porRstn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, rxd = 1'b1;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, txd, memWr, memRd, eeVolt, eeLatch, eeErase, modeSelect, jumpStb;
  logic [15:0] memAddr, jumpAddr, lastJump;
  logic [7:0] memWdata, memRdata, configActive, d0, d1;
  logic [7:0] expQ [$];
  int errorCnt = 0, checkCount = 0, jumps = 0, voltCyc = 0;
  always #12.5 clk = ~clk;
  sel_loader #(.PROG_CYC(PROG), .POLL_CYC(10), .BIT_CYC(BIT)) sel_loader_inst (
    .clk(clk), .rstn(rstn), .porRstn(porRstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .memAddr(memAddr), .memWdata(memWdata),
    .memWr(memWr), .memRd(memRd), .memRdata(memRdata), .eeVolt(eeVolt),
    .eeLatch(eeLatch), .eeErase(eeErase), .modeSelect(modeSelect),
    .configActive(configActive), .jumpAddr(jumpAddr), .jumpStb(jumpStb));
  sel_mem_model sel_mem_model_inst (.clk(clk), .memAddr(memAddr), .memWdata(memWdata),
    .memWr(memWr), .memRd(memRd), .memRdata(memRdata));
  // strobe is one cycle wide, so it is caught here rather than by the host tasks
  always @(posedge clk)
  begin
    if (jumpStb === 1'b1)
    begin
      jumps <= jumps + 1;
      lastJump <= jumpAddr;
    end
    // programming voltage only counts while the latches hold
    if (eeVolt === 1'b1 && eeLatch === 1'b1)
      voltCyc <= voltCyc + 1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finishTest;
    $display("checks %0d mismatches %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic bound(input int n);
    if (n >= 4000)
    begin
      errorCnt++;
      finishTest();
    end
  endtask
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 4000);
    bound(n);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // host shifts one character out; its stop bit runs on while it listens
  task automatic sendc(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 9; i++)
    begin
      rxd <= f[i];
      repeat (BIT) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask
  // host sends one character, then takes every expected reply before going on
  task automatic putc(input logic [7:0] c, input int extra);
    logic [9:0] f;
    int n;
    expQ.push_back(c);
    if (extra >= 0)
      expQ.push_back(extra[7:0]);
    sendc(c);
    while (expQ.size() > 0)
    begin
      n = 0;
      while (txd !== 1'b0 && n < 4000)
      begin
        @(posedge clk);
        n++;
      end
      bound(n);
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT) @(posedge clk);
        f[i] = txd;
      end
      repeat (BIT) @(posedge clk);
      check(f[7:0], expQ.pop_front());
    end
  endtask
  function automatic logic [7:0] hx(input logic [3:0] v);
    return v < 4'ha ? 8'h30 + v : 8'h37 + v;
  endfunction
  task automatic putb(input logic [7:0] b, input int extra);
    putc(hx(b[7:4]), -1);
    putc(hx(b[3:0]), extra);
  endtask
  task automatic rec(input logic [7:0] t, input logic [15:0] a, input int n,
    input logic [7:0] x0, input logic [7:0] x1, input int e0);
    putc(8'h53, -1);
    putc(t, -1);
    putb(8'(n + 3), -1);
    putb(a[15:8], -1);
    putb(a[7:0], -1);
    if (n > 0)
    begin
      putb(x0, e0);
      putb(x1, -1);
    end
    putb(8'($urandom_range(255)), -1);
  endtask
  initial
  begin
    logic [31:0] rd;
    logic err;
    int noise;
    void'($urandom(32'h7baa));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    porRstn <= 1'b1;
    apb(1'b0, 16'h40fc, 32'h0, rd, err);
    check(rd, 32'hff);
    apb(1'b0, 16'h4000, 32'h0, rd, err);
    check(err, 1'b1);
    apb(1'b1, 16'h40fc, 32'h0c, rd, err);
    apb(1'b1, 16'h4100, 32'h1, rd, err);
    // the loader leaves idle one edge after enable lands
    @(posedge clk);
    check(modeSelect, 1'b1);
    check(configActive, 8'hff);
    $display("done regs");
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    putc(8'h0d, -1);
    putc(8'h51, -1);
    putc(8'h58, -1);
    putc(8'h7a, -1);
    rec(8'h31, 16'hc010, 2, d0, d1, -1);
    check(sel_mem_model_inst.mem[16'he010], d0);
    check(sel_mem_model_inst.mem[16'he011], d1);
    rec(8'h39, 16'h0000, 0, 8'h0, 8'h0, -1);
    check(jumps, 0);
    rec(8'h39, 16'h1234, 0, 8'h0, 8'h0, -1);
    check(jumps, 1);
    check(lastJump, 16'h1234);
    $display("done external");
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check(configActive, 8'h0c);
    apb(1'b1, 16'h4100, 32'h1, rd, err);
    putc(8'h0d, -1);
    putc(8'h56, -1);
    rec(8'h31, 16'h0020, 2, 8'h7b, 8'h7b, 8'h7a);
    $display("done verify");
    apb(1'b1, 16'h4100, 32'h0, rd, err);
    apb(1'b1, 16'h4100, 32'h1, rd, err);
    putc(8'h0d, -1);
    putc(8'h49, -1);
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    rec(8'h31, 16'h0040, 2, d0, d1, -1);
    check(voltCyc, 4 * PROG);
    check(sel_mem_model_inst.mem[16'h0040], d0);
    check(sel_mem_model_inst.mem[16'h0041], d1);
    rec(8'h31, 16'h103f, 2, 8'h3c, d0, -1);
    check(sel_mem_model_inst.mem[16'h103f], 8'h65);
    check(sel_mem_model_inst.mem[16'h1040], d0);
    check(configActive, 8'h0c);
    $display("done internal");
    // a write into the read-only window fails and must silence the loader
    putc(8'h53, -1);
    putc(8'h31, -1);
    putb(8'h04, -1);
    putb(8'h80, -1);
    putb(8'h00, -1);
    putb(8'h11, -1);
    sendc(8'h30);
    noise = 0;
    repeat (600)
    begin
      @(posedge clk);
      if (txd !== 1'b1)
        noise++;
    end
    check(noise, 0);
    apb(1'b0, 16'h4104, 32'h0, rd, err);
    check(rd, 32'h8d);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check(configActive, 8'h3c);
    $display("done hang");
    finishTest();
  end
endmodule // sel_loader_tb_top
`default_nettype wire
